// ---- hw/wdt_top.sv ----
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_top #(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic wdog_reset_seen_i,
  input wire logic tick_32k_i,
  input wire logic supply_monitor_interrupt_i,
  input wire wdt_pkg::wdt_sfr_req_t sfr_req_i,
  output logic [7:0] watchdog_control_o,
  output logic wdt_reset_req_o,
  output logic wdt_irq_o
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [3:0] timeout_scale_select;
  logic interrupt_response_select;
  logic timeout_flag;
  logic watchdog_enable;
  logic write_unlock_bit;
  logic [CNT_W-1:0] count;
  logic timeout_hit;
  logic ctrl_hit;
  logic ctrl_ok;
  logic [7:0] cur_ctrl;
  logic [7:0] next_ctrl;

  logic [CNT_W-1:0] period_last;
  wdt_state_t phase;
  wdt_state_t next_phase;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Last count of a period. The span is one bit wider than the counter,
  // because the longest period wraps all sixteen bits.
  function automatic logic [CNT_W-1:0] last_of(input logic [3:0] scale);
    logic [3:0] s;
    logic [CNT_W:0] span;
    s = (scale > `WDT_SCALE_MAX) ? `WDT_SCALE_MAX : scale;
    span = (CNT_W+1)'(1) << (5'(s) + 5'(`WDT_BASE_SHIFT));
    last_of = CNT_W'(span - (CNT_W+1)'(1));
  endfunction

  // ----------------------------------------------------------------
  // Write qualification
  // ----------------------------------------------------------------
  assign cur_ctrl = {timeout_scale_select, interrupt_response_select, timeout_flag,
                     watchdog_enable, write_unlock_bit};
  assign ctrl_hit = sfr_req_i.wr && (sfr_req_i.addr == `WDT_CTRL_ADDR);
  // Unlock must come from the instruction just before; setting the unlock
  // bit alone is allowed while it is clear so the first step can happen.
  assign ctrl_ok = ctrl_hit && write_unlock_bit;

  always_comb begin
    next_ctrl = cur_ctrl;
    if (sfr_req_i.bit_wr) begin
      next_ctrl[sfr_req_i.bit_sel] = sfr_req_i.bit_val;
    end else begin
      next_ctrl = sfr_req_i.wdata;
    end
  end

  assign period_last = last_of(timeout_scale_select);
  // Only a tick can complete a period, so the count never skips the end
  assign timeout_hit = watchdog_enable && tick_32k_i && (count == period_last);

  // ----------------------------------------------------------------
  // Unlock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      write_unlock_bit <= 1'b0;
    end else if (ctrl_hit && next_ctrl[`WDT_UNLOCK_BIT] && !ctrl_ok) begin
      write_unlock_bit <= 1'b1;
    end else if (sfr_req_i.wr) begin
      write_unlock_bit <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Scale and response fields
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      timeout_scale_select <= 4'(`WDT_CTRL_RESET >> `WDT_SCALE_LSB);
    end else if (ctrl_ok) begin
      timeout_scale_select <= next_ctrl[`WDT_SCALE_MSB:`WDT_SCALE_LSB];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      interrupt_response_select <= 1'b0;
    end else if (ctrl_ok) begin
      interrupt_response_select <= next_ctrl[`WDT_IRQ_SEL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Enable
  // ----------------------------------------------------------------
  // Enable drops on hardware reset, supply alarm, or own reset-mode timeout
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || supply_monitor_interrupt_i) begin
      watchdog_enable <= 1'b0;
    end else if (timeout_hit && !interrupt_response_select) begin
      watchdog_enable <= 1'b0;
    end else if (ctrl_ok) begin
      watchdog_enable <= next_ctrl[`WDT_ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Status flag
  // ----------------------------------------------------------------
  // Flag survives a reset that this block caused; timeout beats a clear
  always_ff @(posedge clk_sys_i) begin
    if (reset_i && !wdog_reset_seen_i) begin
      timeout_flag <= 1'b0;
    end else if (reset_i) begin
      timeout_flag <= timeout_flag;
    end else if (timeout_hit) begin
      timeout_flag <= 1'b1;
    end else if (ctrl_ok && !next_ctrl[`WDT_FLAG_BIT]) begin
      timeout_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Counter on the slow timebase
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !watchdog_enable) begin
      count <= '0;
    end else if (ctrl_ok && next_ctrl[`WDT_ENABLE_BIT]) begin
      count <= '0;
    end else if (timeout_hit) begin
      count <= '0;
    end else if (tick_32k_i) begin
      count <= count + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Fire lasts one cycle, so each timeout yields exactly one pulse
  always_comb begin
    next_phase = phase;
    case (phase)
      WDT_IDLE: begin
        if (watchdog_enable) begin
          next_phase = WDT_RUN;
        end
      end
      WDT_RUN: begin
        if (timeout_hit) begin
          next_phase = WDT_FIRE;
        end else if (!watchdog_enable) begin
          next_phase = WDT_IDLE;
        end
      end
      WDT_FIRE: begin
        if (watchdog_enable) begin
          next_phase = WDT_RUN;
        end else begin
          next_phase = WDT_IDLE;
        end
      end
      default: begin
        next_phase = WDT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      phase <= WDT_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // ----------------------------------------------------------------
  // Responses
  // ----------------------------------------------------------------
  // The interrupt bypasses any global gate: it is routed to a fixed
  // high-priority input of the interrupt controller.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wdt_reset_req_o <= 1'b0;
    end else begin
      wdt_reset_req_o <= (next_phase == WDT_FIRE) && !interrupt_response_select;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wdt_irq_o <= 1'b0;
    end else begin
      wdt_irq_o <= (next_phase == WDT_FIRE) && interrupt_response_select;
    end
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      watchdog_control_o <= `WDT_CTRL_RESET;
    end else begin
      watchdog_control_o <= cur_ctrl;
    end
  end
endmodule

// ---- hw/wdt_params.svh ----
// Operation
// - Sixteen-bit counter advanced by 32.768 kHz ticks
// - Timeout is two-power-scale times 512 ticks, with scale above 7 treated as 7
// - Scale field sits in control bits 7:4
// - No timeout action while enable is clear
// - Unrefreshed elapsed period raises reset or interrupt
// - Writing enable one also clears the counter
// - Enable cleared by write, watchdog reset, supply
// - Control write needs unlock set just before
// - Response bit 3 selects interrupt over reset
// - Interrupt is fixed high priority, unmaskable
// - Status bit 2 set on timeout, cleared
// - Status flag survives watchdog-caused reset
// - Control at C0H, bit addressable, resets 10H
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define WDT_CTRL_ADDR 8'hC0
`define WDT_CTRL_RESET 8'h10
`define WDT_SCALE_MSB 7
`define WDT_SCALE_LSB 4
`define WDT_IRQ_SEL_BIT 3
`define WDT_FLAG_BIT 2
`define WDT_ENABLE_BIT 1
`define WDT_UNLOCK_BIT 0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WDT_BASE_SHIFT 9
`define WDT_SCALE_MAX 4'h7

`endif

// ---- hw/wdt_pkg.sv ----
package wdt_pkg;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic bit_val;
  } wdt_sfr_req_t;

  typedef enum logic [1:0] {
    WDT_IDLE = 2'b00,
    WDT_RUN = 2'b01,
    WDT_FIRE = 2'b10
  } wdt_state_t;
endpackage

// ---- verification/wdt_chk_sva.sv ----
`timescale 1ns/1ps
module wdt_chk import wdt_pkg::*; (
  input wire logic clk_sys_i, reset_i, wdog_reset_seen_i, tick_32k_i,
  input wire logic supply_monitor_interrupt_i,
  input wire wdt_sfr_req_t sfr_req_i,
  input wire logic [7:0] watchdog_control_o,
  input wire logic wdt_reset_req_o, wdt_irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Tracks whether the previous strobe could have armed the unlock
  logic mb;
  wire [7:0] c = watchdog_control_o;
  wire [7:0] d = sfr_req_i.wdata;
  wire p = wdt_reset_req_o | wdt_irq_o;
  wire ad = sfr_req_i.addr == 8'hC0;
  wire wc = sfr_req_i.wr && ad && !sfr_req_i.bit_wr;
  wire arm = ad && (sfr_req_i.bit_wr ? sfr_req_i.bit_sel == 3'h0 && sfr_req_i.bit_val : d[0]);
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) mb <= 1'b0;
    else if (sfr_req_i.wr) mb <= arm && !mb;
  end
  property p_en; p |-> c[1]; endproperty
  a_en: assert property (p_en) else $error("pulse while off");
  property p_flag; p |=> c[2]; endproperty
  a_flag: assert property (p_flag) else $error("flag not set");
  property p_sel; p |-> wdt_irq_o == c[3]; endproperty
  a_sel: assert property (p_sel) else $error("wrong response");
  property p_rdis; wdt_reset_req_o |=> !c[1]; endproperty
  a_rdis: assert property (p_rdis) else $error("enable kept");
  property p_ion; wdt_irq_o |=> c[1] && !wdt_irq_o; endproperty
  a_ion: assert property (p_ion) else $error("periodic stop");
  property p_psm; supply_monitor_interrupt_i |-> ##2 !c[1]; endproperty
  a_psm: assert property (p_psm) else $error("supply no clear");
  property p_lock; wc && !mb |=> ##1 c[7:3] == $past(c[7:3]); endproperty
  a_lock: assert property (p_lock) else $error("locked write taken");
  property p_one; wdt_reset_req_o |=> !wdt_reset_req_o; endproperty
  a_one: assert property (p_one) else $error("long pulse");
  c_rst: cover property (wdt_reset_req_o);
  c_irq: cover property (wdt_irq_o);
  c_psm: cover property (supply_monitor_interrupt_i);
endmodule
bind wdt_top wdt_chk u_chk(.*);

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  import wdt_pkg::*;
  logic clk_sys_i = 0, reset_i = 1, seen = 0, supply_monitor_interrupt = 0, rst, irq, tk = 1, half = 0;
  wdt_sfr_req_t r = '0;
  logic [7:0] c;
  int bad_count = 0, samples_checked = 0, cyc = 0, seed = 13, n, s, np = 0;
  wdt_top u_dut(.clk_sys_i(clk_sys_i), .reset_i(reset_i), .wdog_reset_seen_i(seen),
    .tick_32k_i(tk), .supply_monitor_interrupt_i(supply_monitor_interrupt), .sfr_req_i(r),
    .watchdog_control_o(c), .wdt_reset_req_o(rst), .wdt_irq_o(irq));
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) #1 tk = half ? ~tk : 1'b1;
  always @(posedge clk_sys_i) begin
    np += rst;
    if (++cyc > 30000) begin bad_count++; give_verdict(); end
  end
  // Ticks every cycle while half is clear, so the period is counted in clocks
  function bit ok(int k, int sc);
    return k > (1 << (sc + 9)) - 8 && k < (1 << (sc + 9)) + 8;
  endfunction
  task give_verdict();
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task ck(input [7:0] v, e);
    samples_checked++;
    if (v !== e) begin bad_count++; $display("mismatch %0t %h %h", $time, v, e); end
  endtask
  task st(int k); repeat (k) @(posedge clk_sys_i); #1; endtask
  task wr(input [7:0] a, d); st(1); r.wr = 1; r.addr = a; r.wdata = d; st(1); r.wr = 0; endtask
  task uw(input [7:0] d); wr(8'hC0, 8'h01); wr(8'hC0, d); endtask
  task wt(); n = 0; while (!(rst | irq)) begin st(1); n++; end endtask
  task rs(input logic w); reset_i = 1; seen = w; st(2); reset_i = 0; seen = 0; st(1); endtask
  initial begin
    rs(0); ck(c, 8'h10);
    wr(8'hC0, 8'h72); st(2); ck(c, 8'h10);
    wr(8'hC0, 8'h01); wr(8'h80, 8'h00); wr(8'hC0, 8'h72); st(2); ck(c, 8'h10);
    uw(8'h02); wt(); ck(rst, 1'b1); ck(ok(n, 0), 1'b1);
    st(2); ck(c, 8'h04);
    rs(1); ck(c, 8'h14);
    rs(0); ck(c, 8'h10);
    s = {$random(seed)} % 3;
    uw({s[3:0], 4'hA}); wt(); st(1); wt(); ck(irq, 1'b1); ck(ok(n, s), 1'b1);
    st(1); ck(c, {s[3:0], 4'hE});
    n = np; repeat (3) begin st(300); uw(8'h02); end
    ck(8'(np), 8'(n));
    supply_monitor_interrupt = 1; st(1); supply_monitor_interrupt = 0; st(2); ck(c[1], 1'b0);
    half = 1; uw(8'h02); wt(); ck(rst, 1'b1); ck(ok(n / 2, 0), 1'b1);
    give_verdict();
  end
endmodule
